// ---- hw/bsd_pkg.sv ----
// types of the break-free session start detector
package bsd_pkg;
   typedef enum logic [2:0] {
      BSD_B300   = 3'h0,
      BSD_B600   = 3'h1,
      BSD_B1200  = 3'h2,
      BSD_B2400  = 3'h3,
      BSD_B4800  = 3'h4,
      BSD_B9600  = 3'h5,
      BSD_B19200 = 3'h6
   } bsd_baud_t;
   typedef enum logic [1:0] {
      BSD_PAR_NONE = 2'h0,
      BSD_PAR_ODD  = 2'h1,
      BSD_PAR_EVEN = 2'h2
   } bsd_par_t;
   typedef enum logic [3:0] {
      BSD_RX_IDLE  = 4'h1,
      BSD_RX_START = 4'h2,
      BSD_RX_DATA  = 4'h4,
      BSD_RX_STOP  = 4'h8
   } bsd_rx_st_t;
   typedef enum logic [1:0] {
      BSD_M_IDLE = 2'h1,
      BSD_M_SOF  = 2'h2
   } bsd_match_t;
   typedef struct packed {
      logic [7:0] data;
      logic       ferr;
      logic       perr;
   } bsd_char_t;
   typedef struct packed {
      bsd_rx_st_t  st;
      logic [23:0] cnt;
      logic [3:0]  nbit;
      logic [8:0]  sh;
      bsd_char_t   ch;
      logic        vld;
   } bsd_rx_state_t;
   typedef struct packed {
      logic [1:0]  sync;
      logic [23:0] low_cnt;
      logic        brk_seen;
      logic        armed;
      bsd_match_t  m;
      logic        bf_en;
      logic        bf_act;
      logic        locked;
      bsd_baud_t   auto_rate;
      bsd_baud_t   rate;
      bsd_par_t    par;
      logic        start;
      logic        ext;
      logic        by_brk;
      logic        brk;
      logic [7:0]  data;
      logic        vld;
   } bsd_top_state_t;
endpackage

// ---- hw/bsd_regs.svh ----
// constants of the break-free session start detector
// Functional notes
// - a normal break arms the port; the next attach then starts a session
// - in break-free mode an attach alone starts a session, no break needed
// - NUL characters, with or without framing error, are ignored entirely
// - break-free detection is live only at 1200 baud or faster
// - at 300 and 600 baud an attach is accepted only after a break
// - auto-baud steps only on received breaks, never on attach traffic
// - unconfigured port hunts 9600 or 19200 baud, odd parity, one stop
// - command 7004 disables break-free mode, 7005 enables it again
// - break-free mode is enabled out of reset
// - port is slave only; sessions begin only from master traffic
`ifndef BSD_REGS_SVH
`define BSD_REGS_SVH
`define BSD_CLK_HZ      250000000
`define BSD_BAUD_300    300
`define BSD_BAUD_600    600
`define BSD_BAUD_1200   1200
`define BSD_BAUD_2400   2400
`define BSD_BAUD_4800   4800
`define BSD_BAUD_9600   9600
`define BSD_BAUD_19200  19200
`define BSD_MIN_BIT_CYC 4
`define BSD_FRAME_BITS  4'ha
`define BSD_CMD_BF_OFF  16'h1b5c
`define BSD_CMD_BF_ON   16'h1b5d
`define BSD_BF_RST      1'b1
`define BSD_SYNC_RST    2'h3
`define BSD_NUL         8'h00
`endif

// ---- hw/bsd_rx.sv ----
// character receiver with mid-bit sampling
`timescale 1ns/1ns
`default_nettype none
module bsd_rx
(
   input  wire logic              clk,
   input  wire logic              rstn,
   input  wire logic              rxd,
   input  wire logic [23:0]       bit_cyc,
   input  wire logic              par_en,
   input  wire logic              par_odd,
   output bsd_pkg::bsd_char_t     ch,
   output var logic               vld
);
   bsd_pkg::bsd_rx_state_t s_r;
   bsd_pkg::bsd_rx_state_t s_nxt;
   logic [3:0]             last;

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.vld = 1'b0;
      last = par_en ? 4'h8 : 4'h7;
      case (s_r.st)
         bsd_pkg::BSD_RX_IDLE:
            if (!rxd)
            begin
               s_nxt.st = bsd_pkg::BSD_RX_START;
               s_nxt.cnt = bit_cyc >> 1;
            end
         bsd_pkg::BSD_RX_START:
            if (s_r.cnt != 24'h0)
               s_nxt.cnt = s_r.cnt - 24'h1;
            else if (rxd)
               s_nxt.st = bsd_pkg::BSD_RX_IDLE;
            else
            begin
               s_nxt.st = bsd_pkg::BSD_RX_DATA;
               s_nxt.cnt = bit_cyc - 24'h1;
               s_nxt.nbit = 4'h0;
            end
         bsd_pkg::BSD_RX_DATA:
            if (s_r.cnt != 24'h0)
               s_nxt.cnt = s_r.cnt - 24'h1;
            else
            begin
               s_nxt.sh = {rxd, s_r.sh[8:1]};
               s_nxt.cnt = bit_cyc - 24'h1;
               s_nxt.nbit = s_r.nbit + 4'h1;
               if (s_r.nbit == last)
                  s_nxt.st = bsd_pkg::BSD_RX_STOP;
            end
         bsd_pkg::BSD_RX_STOP:
            if (s_r.cnt != 24'h0)
               s_nxt.cnt = s_r.cnt - 24'h1;
            else
            begin
               s_nxt.ch.data = par_en ? s_r.sh[7:0] : s_r.sh[8:1];
               s_nxt.ch.ferr = !rxd;
               s_nxt.ch.perr = par_en && ((^s_r.sh) != par_odd);
               s_nxt.vld = 1'b1;
               s_nxt.st = bsd_pkg::BSD_RX_IDLE;
            end
         default:
            s_nxt.st = bsd_pkg::BSD_RX_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s_r <= '0;
         s_r.st <= bsd_pkg::BSD_RX_IDLE;
      end
      else
         s_r <= s_nxt;
   end

   assign ch = s_r.ch;
   assign vld = s_r.vld;

   chk_rx_valid_pulse: assert property (@(posedge clk) disable iff (!rstn)
      vld |=> !vld) else $error("receiver valid longer than one cycle");
endmodule // bsd_rx
`default_nettype wire

// ---- hw/bsd_top.sv ----
// break-free session start detector top
`timescale 1ns/1ns
`default_nettype none
`include "bsd_regs.svh"
module bsd_top
#(
   parameter int unsigned CLK_HZ    = `BSD_CLK_HZ,
   parameter logic [7:0]  ATT_SOF   = 8'h1b,
   parameter logic [7:0]  ATT_BASIC = 8'h41,
   parameter logic [7:0]  ATT_EXT   = 8'h58
)
(
   input  wire logic                CLK_SYS,
   input  wire logic                RSTN,
   input  wire logic                RXD,
   input  wire logic                CFG_VALID,
   input  wire bsd_pkg::bsd_baud_t  CFG_BAUD,
   input  wire bsd_pkg::bsd_par_t   CFG_PARITY,
   input  wire logic                CMD_VALID,
   input  wire logic [15:0]         CMD_CODE,
   output logic                     SESSION_START,
   output logic                     SESSION_EXT,
   output logic                     SESSION_BRK,
   output logic                     BREAK_DET,
   output logic                     BF_ENABLE,
   output logic                     BF_ACTIVE,
   output bsd_pkg::bsd_baud_t       ACTIVE_BAUD,
   output logic [7:0]               RX_DATA,
   output logic                     RX_VALID
);
   if (CLK_HZ / `BSD_BAUD_19200 < `BSD_MIN_BIT_CYC)
   begin : g_bad_clk
      $error("clock too slow for 19200 baud");
   end
   if (CLK_HZ / `BSD_BAUD_300 >= 32'h0100_0000)
   begin : g_bad_cnt
      $error("bit counter too narrow for this clock");
   end

   bsd_pkg::bsd_top_state_t s_r;
   bsd_pkg::bsd_top_state_t s_nxt;
   bsd_pkg::bsd_char_t      rx_ch;
   logic                    rx_vld;
   logic [23:0]             bitc;
   logic [23:0]             frame;
   logic                    nul;
   logic                    good;
   logic                    cand;
   logic                    rate_ok;

   function automatic logic [23:0] bit_cycles(bsd_pkg::bsd_baud_t b);
      case (b)
         bsd_pkg::BSD_B300:  bit_cycles = 24'(CLK_HZ / `BSD_BAUD_300);
         bsd_pkg::BSD_B600:  bit_cycles = 24'(CLK_HZ / `BSD_BAUD_600);
         bsd_pkg::BSD_B1200: bit_cycles = 24'(CLK_HZ / `BSD_BAUD_1200);
         bsd_pkg::BSD_B2400: bit_cycles = 24'(CLK_HZ / `BSD_BAUD_2400);
         bsd_pkg::BSD_B4800: bit_cycles = 24'(CLK_HZ / `BSD_BAUD_4800);
         bsd_pkg::BSD_B9600: bit_cycles = 24'(CLK_HZ / `BSD_BAUD_9600);
         default:            bit_cycles = 24'(CLK_HZ / `BSD_BAUD_19200);
      endcase
   endfunction

   bsd_rx u_rx
   (
      .clk     (CLK_SYS),
      .rstn    (RSTN),
      .rxd     (s_r.sync[1]),
      .bit_cyc (bitc),
      .par_en  (s_r.par != bsd_pkg::BSD_PAR_NONE),
      .par_odd (s_r.par == bsd_pkg::BSD_PAR_ODD),
      .ch      (rx_ch),
      .vld     (rx_vld)
   );

   always_comb
   begin
      s_nxt = s_r;
      s_nxt.sync = {s_r.sync[0], RXD};
      s_nxt.start = 1'b0;
      s_nxt.brk = 1'b0;
      s_nxt.vld = 1'b0;
      bitc = bit_cycles(s_r.rate);
      // start, data, optional parity, stop
      frame = 24'(bitc * ((s_r.par == bsd_pkg::BSD_PAR_NONE) ?
         `BSD_FRAME_BITS : `BSD_FRAME_BITS + 4'h1));
      // auto-baud: odd parity, one stop
      s_nxt.rate = CFG_VALID ? CFG_BAUD : s_r.auto_rate;
      s_nxt.par = CFG_VALID ? CFG_PARITY : bsd_pkg::BSD_PAR_ODD;
      rate_ok = s_r.rate >= bsd_pkg::BSD_B1200;
      s_nxt.bf_act = s_r.bf_en && rate_ok;
      if (CMD_VALID && CMD_CODE == `BSD_CMD_BF_OFF)
         s_nxt.bf_en = 1'b0;
      else if (CMD_VALID && CMD_CODE == `BSD_CMD_BF_ON)
         s_nxt.bf_en = 1'b1;
      nul = rx_ch.data == `BSD_NUL;
      good = rx_vld && !nul && !rx_ch.ferr && !rx_ch.perr;
      cand = 1'b0;
      case (s_r.m)
         bsd_pkg::BSD_M_IDLE:
            if (good && rx_ch.data == ATT_SOF)
               s_nxt.m = bsd_pkg::BSD_M_SOF;
         bsd_pkg::BSD_M_SOF:
            if (good)
            begin
               cand = rx_ch.data == ATT_BASIC || rx_ch.data == ATT_EXT;
               s_nxt.m = (rx_ch.data == ATT_SOF) ? bsd_pkg::BSD_M_SOF :
                  bsd_pkg::BSD_M_IDLE;
            end
            else if (rx_vld && !nul)
               s_nxt.m = bsd_pkg::BSD_M_IDLE;
         default:
            s_nxt.m = bsd_pkg::BSD_M_IDLE;
      endcase
      if (good)
      begin
         s_nxt.data = rx_ch.data;
         s_nxt.vld = 1'b1;
      end
      // session begins only on a received attach
      if (cand && (s_r.armed || s_r.bf_act))
      begin
         s_nxt.start = 1'b1;
         s_nxt.ext = rx_ch.data == ATT_EXT;
         s_nxt.by_brk = s_r.armed;
         s_nxt.armed = 1'b0;
         s_nxt.locked = s_r.locked || !CFG_VALID;
      end
      if (s_r.sync[1])
      begin
         s_nxt.low_cnt = 24'h0;
         s_nxt.brk_seen = 1'b0;
      end
      else if (!s_r.brk_seen)
      begin
         // strictly longer than a frame, so NUL with framing error is no break
         if (s_r.low_cnt >= frame)
         begin
            s_nxt.brk = 1'b1;
            s_nxt.brk_seen = 1'b1;
            s_nxt.armed = 1'b1;
            s_nxt.m = bsd_pkg::BSD_M_IDLE;
            if (!CFG_VALID && !s_r.locked)
               s_nxt.auto_rate = (s_r.auto_rate == bsd_pkg::BSD_B9600) ?
                  bsd_pkg::BSD_B19200 : bsd_pkg::BSD_B9600;
         end
         else
            s_nxt.low_cnt = s_r.low_cnt + 24'h1;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RSTN)
   begin
      if (!RSTN)
      begin
         s_r <= '0;
         s_r.sync <= `BSD_SYNC_RST;
         s_r.m <= bsd_pkg::BSD_M_IDLE;
         s_r.bf_en <= `BSD_BF_RST;
         s_r.auto_rate <= bsd_pkg::BSD_B9600;
         s_r.rate <= bsd_pkg::BSD_B9600;
         s_r.par <= bsd_pkg::BSD_PAR_ODD;
      end
      else
         s_r <= s_nxt;
   end

   assign SESSION_START = s_r.start;
   assign SESSION_EXT = s_r.ext;
   assign SESSION_BRK = s_r.by_brk;
   assign BREAK_DET = s_r.brk;
   assign BF_ENABLE = s_r.bf_en;
   assign BF_ACTIVE = s_r.bf_act;
   assign ACTIVE_BAUD = s_r.rate;
   assign RX_DATA = s_r.data;
   assign RX_VALID = s_r.vld;

   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (!RSTN);

   sequence seq_cmd_off;
      CMD_VALID && CMD_CODE == `BSD_CMD_BF_OFF;
   endsequence
   sequence seq_cmd_on;
      CMD_VALID && CMD_CODE == `BSD_CMD_BF_ON;
   endsequence
   sequence seq_nul_char;
      rx_vld && nul && !s_nxt.brk;
   endsequence

   chk_brk_length: assert property (s_r.brk |->
      $past(s_r.low_cnt) >= $past(frame))
      else $error("break flagged before a full frame");
   chk_armed_clear: assert property ($fell(s_r.armed) |-> s_r.start)
      else $error("break arming lost without a session");
   chk_bf_attach: assert property (cand && s_r.bf_act |=> s_r.start)
      else $error("break-free attach not accepted");
   chk_nul_ignored: assert property (seq_nul_char |=>
      $stable(s_r.m) && !s_r.start)
      else $error("NUL character disturbed session detection");
   chk_bf_rate: assert property (s_r.start && !s_r.by_brk |->
      $past(s_r.bf_en, 2) && $past(s_r.rate, 2) >= bsd_pkg::BSD_B1200)
      else $error("break-free session below 1200 baud");
   chk_slow_break: assert property (s_r.start &&
      $past(s_r.rate, 2) < bsd_pkg::BSD_B1200 |-> s_r.by_brk)
      else $error("slow-rate session without break");
   chk_auto_step: assert property ($changed(s_r.auto_rate) |-> s_r.brk)
      else $error("auto-baud moved without a break");
   chk_auto_fmt: assert property (!$past(CFG_VALID) |->
      (s_r.rate == bsd_pkg::BSD_B9600 || s_r.rate == bsd_pkg::BSD_B19200)
      && s_r.par == bsd_pkg::BSD_PAR_ODD)
      else $error("unconfigured port outside auto-baud format");
   chk_cmd_off: assert property (seq_cmd_off |=> !BF_ENABLE)
      else $error("disable command ignored");
   chk_cmd_on: assert property (seq_cmd_on |=> BF_ENABLE)
      else $error("enable command ignored");
   chk_start_cause: assert property (s_r.start |-> $past(rx_vld))
      else $error("session start without received character");
endmodule // bsd_top
`default_nettype wire

// ---- tb/bsd_master.sv ----
// serial master model driving the receive pin
`timescale 1ns/1ns
`default_nettype none
module bsd_master
(
   input  wire logic clk,
   output logic      rxd
);
   initial rxd = 1'b1;
   task automatic bit_out(input logic v, input int n);
      rxd <= v;
      repeat (n) @(posedge clk);
   endtask
   // start, 8 data lsb first, optional odd parity, stop, idle gap
   task automatic send_char(input logic [7:0] d, input int n,
                            input logic par, input logic stop);
      int i;
      bit_out(1'b0, n);
      for (i = 0; i < 8; i++)
         bit_out(d[i], n);
      if (par)
         bit_out(~^d, n);
      bit_out(stop, n);
      bit_out(1'b1, 3 * n);
   endtask
   task automatic send_break(input int n);
      bit_out(1'b0, 24 * n);
      // receiver may still be mid-frame when the break ends
      bit_out(1'b1, 12 * n);
   endtask
endmodule // bsd_master
`default_nettype wire

// ---- tb/bsd_top_test.sv ----
// testbench of the break-free session start detector
`timescale 1ns/1ns
`default_nettype none
module bsd_top_test;
   localparam int unsigned HZ = 76800;
   logic               clk = 1'b0;
   logic               rstn = 1'b0;
   logic               cfg_v = 1'b0;
   logic               cmd_v = 1'b0;
   logic [15:0]        cmd = 16'h0000;
   bsd_pkg::bsd_baud_t cfg_b = bsd_pkg::BSD_B300;
   bsd_pkg::bsd_par_t  cfg_p = bsd_pkg::BSD_PAR_NONE;
   logic               rxd, s_start, s_ext, s_brk, brk_det, bf_en, bf_act;
   logic               rx_v;
   logic [7:0]         rx_d, last_rx = 8'h00;
   bsd_pkg::bsd_baud_t baud;
   logic [1:0]         last_sess = 2'h0, m_last = 2'h0;
   logic               m_arm = 1'b0, m_en = 1'b1, m_lock = 1'b0;
   int                 fails = 0, cmp_count = 0, n_sess = 0, n_brk = 0;
   int                 m_ns = 0, m_nb = 0, m_auto = 5, i;
   int                 rates [7] = '{300, 600, 1200, 2400, 4800, 9600, 19200};
   always #2 clk = ~clk;
   bsd_master mst (.clk(clk), .rxd(rxd));
   bsd_top #(.CLK_HZ(HZ)) dut_u
   (
      .CLK_SYS(clk), .RSTN(rstn), .RXD(rxd), .CFG_VALID(cfg_v),
      .CFG_BAUD(cfg_b), .CFG_PARITY(cfg_p), .CMD_VALID(cmd_v),
      .CMD_CODE(cmd), .SESSION_START(s_start), .SESSION_EXT(s_ext),
      .SESSION_BRK(s_brk), .BREAK_DET(brk_det), .BF_ENABLE(bf_en),
      .BF_ACTIVE(bf_act), .ACTIVE_BAUD(baud), .RX_DATA(rx_d),
      .RX_VALID(rx_v)
   );
   always @(posedge clk)
   begin
      if (s_start === 1'b1)
      begin
         n_sess    <= n_sess + 1;
         last_sess <= {s_ext, s_brk};
      end
      if (brk_det === 1'b1)
         n_brk <= n_brk + 1;
      if (rx_v === 1'b1)
         last_rx <= rx_d;
   end
   task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                        input string msg);
      cmp_count++;
      if (seen !== exp)
      begin
         fails++;
         $display("wrong value at %0t: %s", $time, msg);
      end
   endtask
   function automatic int cur();
      return cfg_v ? int'(cfg_b) : m_auto;
   endfunction
   task automatic attach(input logic ext, input logic nul);
      int         n;
      logic       p;
      logic [7:0] t;
      n = HZ / rates[cur()];
      p = cfg_v ? (cfg_p == bsd_pkg::BSD_PAR_ODD) : 1'b1;
      t = ext ? 8'h58 : 8'h41;
      mst.send_char(8'h1b, n, p, 1'b1);
      if (nul)
      begin
         mst.send_char(8'h00, n, p, 1'b1);
         mst.send_char(8'h00, n, p, 1'b0);
      end
      mst.send_char(t, n, p, 1'b1);
      if (m_arm || (m_en && cur() >= 2))
      begin
         m_ns++;
         m_last = {ext, m_arm};
         m_arm = 1'b0;
         m_lock = m_lock | ~cfg_v;
      end
      check(n_sess[7:0], m_ns[7:0], "session count");
      check({6'h0, last_sess}, {6'h0, m_last}, "session kind");
      check(last_rx, t, "type byte");
   endtask
   task automatic brk();
      int r;
      mst.send_break(HZ / rates[cur()]);
      m_nb++;
      m_arm = 1'b1;
      if (!cfg_v && !m_lock)
         m_auto = (m_auto == 5) ? 6 : 5;
      r = cur();
      check(n_brk[7:0], m_nb[7:0], "break count");
      check({5'h0, baud}, r[7:0], "active rate");
   endtask
   task automatic command(input logic [15:0] c);
      int r;
      cmd_v <= 1'b1;
      cmd   <= c;
      @(posedge clk);
      cmd_v <= 1'b0;
      repeat (3) @(posedge clk);
      if (c == 16'h1b5c)
         m_en = 1'b0;
      if (c == 16'h1b5d)
         m_en = 1'b1;
      r = cur();
      check({7'h0, bf_en}, {7'h0, m_en}, "enable");
      check({7'h0, bf_act}, {7'h0, m_en && r >= 2}, "active");
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial
   begin
      repeat (100000) @(posedge clk);
      fails++;
      summarize();
   end
   initial
   begin
      void'($urandom(32'h44bccd6f));
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
      check({7'h0, bf_en}, 8'h01, "enable out of reset");
      check({5'h0, baud}, 8'h05, "rate out of reset");
      brk();
      attach(1'b1, 1'b0);
      brk();
      attach(1'b0, 1'b1);
      attach(1'b0, 1'b0);
      command(16'h1b5c);
      attach(1'b0, 1'b0);
      command({1'b1, 15'($urandom)});
      command(16'h1b5d);
      attach(1'b1, 1'b1);
      cfg_v <= 1'b1;
      for (i = 0; i < 3; i++)
      begin
         cfg_b <= bsd_pkg::bsd_baud_t'(i);
         command(16'h0000);
         attach(1'b0, 1'b0);
         brk();
         attach(1'b1, 1'b0);
      end
      summarize();
   end
endmodule // bsd_top_test
`default_nettype wire
